// [afr_unit.sv]
`timescale 1ns/10ps
`include "afr_params.svh"
// Summary of operation
// - Controller error indicator lights when bus or controller faults spoil refresh.
// - Bus fault zeroes input data; outputs follow configured hold setting.
// - Supervision timeout keeps inputs and outputs exactly as before.
// - Watchdog fault: input data undefined, outputs follow hold setting.
// - Bad or duplicate unit number: no conversion, zero inputs, outputs 0 V.
// - Unit table mismatch: unconverted, zero data, error lit, run off.
// - Restart only after set then clear of the unit's own restart bit.
// - Power cycle also restarts; restart reloads settings and re-evaluates faults.
// - During restart inputs read zero and outputs sit at zero.
// - An input not in use keeps its conversion data unchanged.
// - Peak hold keeps reported data at the held value.
// - Output held frozen until its conversion enable bit is set.
// - Out-of-range commanded values never update an output.
// - Ratio conversion enabled: report ratio result instead of raw value.
// - Refresh word block starts at word 2000 plus ten times unit number.
module afr_unit
	import afr_pkg::*;
#(
	parameter int NCH = 4,
	parameter int W   = 16
) (
	input  wire logic              mclk_i,
	input  wire logic              nrst_i,
	input  wire logic [6:0]        unit_num_i,
	input  wire logic              unit_dup_i,
	input  wire logic              table_mismatch_i,
	input  wire logic              bus_fault_i,
	input  wire logic              supv_timeout_i,
	input  wire logic              watchdog_timeout_i,
	input  wire logic              restart_req_i,
	input  wire logic [1:0]        hold_cfg_i,
	input  wire logic [NCH-1:0]    in_use_i,
	input  wire logic [NCH-1:0]    peak_hold_i,
	input  wire logic [NCH-1:0]    ratio_en_i,
	input  wire logic [NCH*W-1:0]  raw_in_i,
	input  wire logic [NCH*W-1:0]  ratio_in_i,
	input  wire logic [NCH-1:0]    out_conv_en_i,
	input  wire logic [NCH*W-1:0]  out_cmd_i,
	input  wire logic [NCH*W-1:0]  out_limit_i,
	output logic [NCH*W-1:0]       in_data_o,
	output logic [NCH*W-1:0]       out_val_o,
	output logic                   controller_error_indicator_o,
	output logic                   run_o,
	output logic                   restarting_o,
	output logic                   hold_cfg_err_o,
	output logic [NCH-1:0]         out_range_err_o,
	output logic [15:0]            refresh_base_o
);
	afr_rst_state_t rst_st_ff, nxt_rst_st;
	logic           cfg_ok_ff, nxt_cfg_ok;
	logic [1:0]     hold_ff, nxt_hold;
	logic           err_ff, nxt_err;
	logic           run_ff, nxt_run;
	logic           herr_ff, nxt_herr;
	logic [NCH-1:0] rerr_ff, nxt_rerr;
	logic [15:0]    base_ff, nxt_base;
	logic           rsto_ff, nxt_rsto;
	logic [NCH-1:0]   in_we, out_we;
	logic [NCH*W-1:0] in_wd, out_wd, in_q, out_q;
	logic             unit_bad, restarting, hold_zero;
	logic             normal_ok;

	// Power-on reset leaves the restart FSM in RESTART so the first cycle reloads settings.
	always_comb begin
		nxt_rst_st = rst_st_ff;
		unique case (rst_st_ff)
			AFR_IDLE:    if (restart_req_i) nxt_rst_st = AFR_ARMED;
			AFR_ARMED:   if (!restart_req_i) nxt_rst_st = AFR_RESTART;
			AFR_RESTART: nxt_rst_st = restart_req_i ? AFR_ARMED : AFR_IDLE;
			// The fourth code is unreachable; a stray one restarts, which reloads settings.
			default:     nxt_rst_st = AFR_RESTART;
		endcase
		nxt_rsto = (nxt_rst_st == AFR_RESTART);
	end
	assign restarting = (rst_st_ff != AFR_IDLE);

	assign unit_bad = unit_dup_i || (unit_num_i > `AFR_UNIT_MAX);

	// Settings are only taken on restart, so a changed setting waits for one.
	always_comb begin
		nxt_cfg_ok = cfg_ok_ff;
		nxt_hold   = hold_ff;
		nxt_herr   = herr_ff;
		nxt_base   = base_ff;
		if (rst_st_ff == AFR_RESTART) begin
			nxt_herr   = (hold_cfg_i > `AFR_HOLD_MAX);
			nxt_hold   = nxt_herr ? `AFR_HOLD_CLEAR : hold_cfg_i;
			nxt_cfg_ok = !unit_bad && !table_mismatch_i && !nxt_herr;
			nxt_base   = `AFR_REFRESH_BASE + 16'(unit_num_i) * `AFR_REFRESH_STEP;
		end
		nxt_err = bus_fault_i || watchdog_timeout_i || unit_bad || table_mismatch_i;
		nxt_run = !(unit_bad || table_mismatch_i) && cfg_ok_ff && !restarting;
	end

	assign hold_zero = (hold_ff == `AFR_HOLD_CLEAR);

	// Plain conversion case, used by the range check below to keep its antecedent short.
	assign normal_ok = !restarting && cfg_ok_ff && !unit_bad && !table_mismatch_i
		&& !supv_timeout_i && !bus_fault_i && !watchdog_timeout_i;

	always_comb begin
		in_we  = '0;
		out_we = '0;
		in_wd  = '0;
		out_wd = '0;
		nxt_rerr = rerr_ff;
		for (int i = 0; i < NCH; i++) begin
			if (restarting || unit_bad || table_mismatch_i || !cfg_ok_ff) begin
				in_we[i]  = 1'b1;
				in_wd[i*W +: W] = `AFR_DATA_ZERO;
				out_we[i] = 1'b1;
				out_wd[i*W +: W] = `AFR_OUT_ZERO;
			end else if (supv_timeout_i) begin
				in_we[i]  = 1'b0;
				out_we[i] = 1'b0;
			end else if (bus_fault_i || watchdog_timeout_i) begin
				in_we[i] = bus_fault_i;
				in_wd[i*W +: W] = `AFR_DATA_ZERO;
				out_we[i] = 1'b1;
				if (hold_ff == `AFR_HOLD_LAST) out_we[i] = 1'b0;
				else out_wd[i*W +: W] = hold_zero ? `AFR_OUT_ZERO : out_limit_i[i*W +: W];
			end else begin
				in_we[i] = in_use_i[i] && !peak_hold_i[i];
				in_wd[i*W +: W] = ratio_en_i[i] ? ratio_in_i[i*W +: W]
				                                : raw_in_i[i*W +: W];
				nxt_rerr[i] = out_cmd_i[i*W +: W] > out_limit_i[i*W +: W];
				out_we[i] = out_conv_en_i[i] && !nxt_rerr[i];
				out_wd[i*W +: W] = out_cmd_i[i*W +: W];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_st_ff <= AFR_RESTART;
			cfg_ok_ff <= 1'b0;
			hold_ff   <= `AFR_HOLD_CLEAR;
			err_ff    <= 1'b0;
			run_ff    <= 1'b0;
			herr_ff   <= 1'b0;
			rerr_ff   <= '0;
			base_ff   <= `AFR_REFRESH_BASE;
			rsto_ff   <= 1'b1;
		end else begin
			rst_st_ff <= nxt_rst_st;
			cfg_ok_ff <= nxt_cfg_ok;
			hold_ff   <= nxt_hold;
			err_ff    <= nxt_err;
			run_ff    <= nxt_run;
			herr_ff   <= nxt_herr;
			rerr_ff   <= nxt_rerr;
			base_ff   <= nxt_base;
			rsto_ff   <= nxt_rsto;
		end
	end

	afr_chan_mem #(.WIDTH(W), .DEPTH(NCH)) u_in_mem (
		.mclk_i    (mclk_i),
		.nrst_i    (nrst_i),
		.wr_en_i   (in_we),
		.wr_data_i (in_wd),
		.rd_data_o (in_q)
	);
	afr_chan_mem #(.WIDTH(W), .DEPTH(NCH)) u_out_mem (
		.mclk_i    (mclk_i),
		.nrst_i    (nrst_i),
		.wr_en_i   (out_we),
		.wr_data_i (out_wd),
		.rd_data_o (out_q)
	);

	assign in_data_o                    = in_q;
	assign out_val_o                    = out_q;
	assign controller_error_indicator_o = err_ff;
	assign run_o                        = run_ff;
	assign restarting_o                 = rsto_ff;
	assign hold_cfg_err_o               = herr_ff;
	assign out_range_err_o              = rerr_ff;
	assign refresh_base_o               = base_ff;

	a_restart_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(rst_st_ff == AFR_RESTART) |=> (in_data_o == '0) && (out_val_o == '0))
		else $error("restart did not zero data");
	a_clear_edge: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(rst_st_ff == AFR_ARMED) && !restart_req_i |=> restarting_o)
		else $error("clearing edge missed");
	a_no_early_rst: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(rst_st_ff == AFR_IDLE) |=> !restarting_o)
		else $error("restart without set then clear");
	a_bad_unit: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		unit_bad |=> controller_error_indicator_o && !run_o && (in_data_o == '0))
		else $error("bad unit not handled");
	a_table_err: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		table_mismatch_i |=> controller_error_indicator_o && !run_o && (out_val_o == '0))
		else $error("table mismatch not handled");
	a_timeout_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		supv_timeout_i && !restarting && !unit_bad && !table_mismatch_i && cfg_ok_ff
		|=> $stable(in_data_o) && $stable(out_val_o))
		else $error("timeout changed data");
	a_bus_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		bus_fault_i && !supv_timeout_i
		|=> controller_error_indicator_o && (in_data_o == '0))
		else $error("bus fault did not zero inputs");
	a_unused_keep: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!restarting && cfg_ok_ff && !unit_bad && !table_mismatch_i && !supv_timeout_i
		&& !bus_fault_i && !watchdog_timeout_i && !in_use_i[0]
		|=> $stable(in_data_o[W-1:0]))
		else $error("unused input changed");

	// A restart is the two steps of set and then clear on the unit's own request bit.
	sequence s_req_high;
		restart_req_i;
	endsequence
	sequence s_req_low;
		!restart_req_i;
	endsequence
	a_set_clear: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_req_high ##1 s_req_low |=> restarting_o)
		else $error("set then clear did not restart");
	for (genvar g = 0; g < NCH; g++) begin : g_range_chk
		a_range_keep: assert property (@(posedge mclk_i) disable iff (!nrst_i)
			normal_ok && (out_cmd_i[g*W +: W] > out_limit_i[g*W +: W])
			|=> $stable(out_val_o[g*W +: W]) && out_range_err_o[g])
			else $error("out of range command applied");
	end
endmodule : afr_unit

// [afr_params.svh]
`ifndef AFR_PARAMS_SVH
`define AFR_PARAMS_SVH
`define AFR_DATA_ZERO     16'h0000
`define AFR_OUT_ZERO      16'h0000
`define AFR_UNIT_MAX      7'h5f
`define AFR_HOLD_CLEAR    2'h0
`define AFR_HOLD_LAST     2'h1
`define AFR_HOLD_MAX      2'h2
`define AFR_REFRESH_BASE  16'h07d0
`define AFR_REFRESH_STEP  16'h000a
`define AFR_OUT_FULL      16'hffff
`endif

// [afr_pkg.sv]
package afr_pkg;
	typedef enum logic [1:0] {
		AFR_IDLE,
		AFR_ARMED,
		AFR_RESTART
	} afr_rst_state_t;
endpackage : afr_pkg

// [afr_chan_mem.sv]
`timescale 1ns/10ps
// Per-channel holding registers; read data always come out of a register.
module afr_chan_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic                     mclk_i,
	input  wire logic                     nrst_i,
	input  wire logic [DEPTH-1:0]         wr_en_i,
	input  wire logic [DEPTH*WIDTH-1:0]   wr_data_i,
	output logic      [DEPTH*WIDTH-1:0]   rd_data_o
);
	logic [DEPTH*WIDTH-1:0] mem_ff;
	logic [DEPTH*WIDTH-1:0] nxt_mem;

	always_comb begin
		nxt_mem = mem_ff;
		for (int i = 0; i < DEPTH; i++) begin
			if (wr_en_i[i]) begin
				nxt_mem[i*WIDTH +: WIDTH] = wr_data_i[i*WIDTH +: WIDTH];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mem_ff <= '0;
		end else begin
			mem_ff <= nxt_mem;
		end
	end

	assign rd_data_o = mem_ff;
endmodule : afr_chan_mem

// [afr_ctrl_model.sv]
`timescale 1ns/10ps
// Controller side: one restart bit per unit number, set for a few cycles and then cleared.
module afr_ctrl_model (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic [6:0] unit_i,
	input  wire logic       go_i,
	output logic            restart_req_o
);
	logic [95:0] req_ff;
	logic [2:0]  cnt_ff;
	// Units above 95 own no restart bit, so their line reads low.
	assign restart_req_o = (unit_i <= 7'h5f) ? req_ff[unit_i] : 1'b0;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_ff <= '0;
			cnt_ff <= 3'h0;
		end else if (go_i) begin
			req_ff[unit_i] <= 1'b1;
			cnt_ff         <= 3'h3;
		end else if (cnt_ff != 3'h0) begin
			cnt_ff <= cnt_ff - 3'h1;
		end else begin
			req_ff <= '0;
		end
	end
endmodule : afr_ctrl_model

// [analog_unit_fault_restart_bench.sv]
`timescale 1ns/10ps
module analog_unit_fault_restart_bench;
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [6:0]  unit;
	logic        dup, mism, busf, supv, wdog, go, req;
	logic [1:0]  hold;
	logic [3:0]  use_v, peak, ratio, conv, rerr;
	logic [63:0] raw, rat, cmd, lim, din, dout;
	logic        ind, run, rsto, herr;
	logic [15:0] base;
	int          n_errors = 0;
	int          n_compared = 0;
	logic [63:0] exp_out [3];
	always #5 mclk_i = ~mclk_i;
	afr_ctrl_model ctl (.mclk_i(mclk_i), .nrst_i(nrst_i), .unit_i(unit), .go_i(go),
		.restart_req_o(req));
	afr_unit uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .unit_num_i(unit), .unit_dup_i(dup),
		.table_mismatch_i(mism), .bus_fault_i(busf), .supv_timeout_i(supv),
		.watchdog_timeout_i(wdog), .restart_req_i(req), .hold_cfg_i(hold), .in_use_i(use_v),
		.peak_hold_i(peak), .ratio_en_i(ratio), .raw_in_i(raw), .ratio_in_i(rat),
		.out_conv_en_i(conv), .out_cmd_i(cmd), .out_limit_i(lim), .in_data_o(din),
		.out_val_o(dout), .controller_error_indicator_o(ind), .run_o(run),
		.restarting_o(rsto), .hold_cfg_err_o(herr), .out_range_err_o(rerr),
		.refresh_base_o(base));
	task automatic chk(input logic [159:0] got, input logic [159:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : tick
	task automatic restart();
		go = 1'b1;
		tick(1);
		go = 1'b0;
		tick(10);
	endtask : restart
	task automatic tally_and_finish();
		if (n_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	// The whole sequence needs about 150 cycles; this leaves a wide margin.
	initial begin
		#100us;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		{dup, mism, busf, supv, wdog, go} = '0;
		unit = 7'h05;
		hold = 2'h0;
		{use_v, peak, ratio, conv} = {4'hf, 4'h0, 4'h0, 4'hf};
		raw = 64'h0004_0003_0002_0001;
		rat = 64'h0040_0030_0020_0010;
		cmd = 64'h0100_0100_0100_0100;
		lim = 64'h0800_0800_0800_0800;
		exp_out = '{64'h0, cmd, lim};
		tick(8);
		nrst_i = 1'b1;
		tick(10);
		chk(base, 16'h0802);
		chk({run, ind, rsto, din, dout}, {3'b100, raw, cmd});
		for (int h = 0; h < 3; h++) begin
			hold = h[1:0];
			restart();
			busf = 1'b1;
			tick(3);
			chk({ind, din, dout}, {1'b1, 64'h0, exp_out[h]});
			busf = 1'b0;
			tick(3);
		end
		wdog = 1'b1;
		tick(3);
		chk({ind, dout}, {1'b1, lim});
		wdog = 1'b0;
		supv = 1'b1;
		raw = 64'h0007_0007_0007_0007;
		cmd = 64'h0300_0300_0300_0300;
		tick(3);
		chk({din, dout}, {64'h0004_0003_0002_0001, lim});
		supv = 1'b0;
		raw = 64'h0004_0003_0002_0001;
		cmd = 64'h0100_0100_0100_0100;
		{use_v, peak, ratio} = {4'he, 4'h2, 4'h4};
		tick(4);
		raw = 64'h0009_0008_0001_0000;
		conv = 4'he;
		cmd = 64'h0200_0200_0900_0200;
		tick(4);
		chk(din, 64'h0009_0030_0002_0001);
		chk({rerr, dout}, {4'h2, 64'h0200_0200_0100_0100});
		conv = 4'hf;
		tick(3);
		chk(dout[15:0], 16'h0200);
		go = 1'b1;
		tick(1);
		go = 1'b0;
		tick(2);
		chk({req, run, din, dout}, {2'b10, 128'h0});
		tick(3);
		chk(rsto, 1'b1);
		tick(5);
		chk(run, 1'b1);
		hold = 2'h3;
		restart();
		chk({herr, run}, 2'b10);
		hold = 2'h0;
		unit = 7'h60;
		nrst_i = 1'b0;
		tick(2);
		nrst_i = 1'b1;
		tick(10);
		chk({ind, run, din, dout}, {2'b10, 128'h0});
		unit = 7'h05;
		dup = 1'b1;
		restart();
		chk({ind, run, din, dout}, {2'b10, 128'h0});
		dup = 1'b0;
		mism = 1'b1;
		restart();
		chk({ind, run, din, dout}, {2'b10, 128'h0});
		mism = 1'b0;
		restart();
		chk({herr, run}, 2'b01);
		tally_and_finish();
	end
endmodule : analog_unit_fault_restart_bench
